// ===== trap_ctrl_pkg.sv
package trap_ctrl_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // register offsets on the plain register port
  localparam logic [2:0] OFS_TRAP_STATUS_CONTROL_ONE    = 3'h0;
  localparam logic [2:0] OFS_GLOBAL_ENABLE_EDGE_CONTROL = 3'h1;
  localparam logic [2:0] OFS_SOFT_TRAP_STATUS           = 3'h2;
  localparam logic [2:0] OFS_HARD_TRAP_SOFTWARE_STATUS  = 3'h3;
  localparam logic [2:0] OFS_PENDING_VECTOR_LEVEL       = 3'h4;
  localparam logic [2:0] OFS_EVENT_STATUS               = 3'h5;
  localparam logic [2:0] OFS_EVENT_MASK                 = 3'h6;

  // field positions
  localparam int POS_ADDRESS_FAULT   = 3;
  localparam int POS_STACK_FAULT     = 2;
  localparam int POS_CLOCK_FAILURE   = 1;
  localparam int POS_GLOBAL_ENABLE   = 15;
  localparam int POS_TIMED_DISABLE   = 14;
  localparam int POS_SOFTWARE_TRAP   = 13;
  localparam int POS_EXT_POLARITY    = 0;
  localparam int POS_DMA_SOFT_FAULT  = 5;
  localparam int POS_LOOP_OVERFLOW   = 4;
  localparam int POS_SOFT_HARD_FAULT = 0;
  localparam int POS_NEW_LEVEL       = 8;
  localparam int POS_VECTOR          = 0;

  // event status / mask bit positions
  localparam int EV_ADDRESS = 0;
  localparam int EV_STACK   = 1;
  localparam int EV_CLOCK   = 2;
  localparam int EV_DMA     = 3;
  localparam int EV_LOOP    = 4;
  localparam int EV_SOFTHW  = 5;
  localparam int EV_EXT     = 6;
  localparam int EV_COUNT   = 9;

  // values after reset
  localparam logic       RST_GLOBAL_ENABLE = 1'b1;
  localparam logic [2:0] RST_EXT_POLARITY  = 3'h0;
  localparam logic [7:0] RST_VECTOR        = 8'h00;
  localparam logic [3:0] RST_LEVEL         = 4'h0;

  // trap and interrupt vector codes
  localparam logic [7:0] VEC_CLOCK_FAIL   = 8'h00;
  localparam logic [7:0] VEC_ADDRESS      = 8'h01;
  localparam logic [7:0] VEC_HARD_GENERIC = 8'h02;
  localparam logic [7:0] VEC_STACK        = 8'h03;
  localparam logic [7:0] VEC_MATH         = 8'h04;
  localparam logic [7:0] VEC_DMA          = 8'h05;
  localparam logic [7:0] VEC_SOFT_GENERIC = 8'h06;
  localparam logic [7:0] VEC_EXT_IRQ_ZERO = 8'h08;
  localparam logic [7:0] VEC_CAPTURE_ONE  = 8'h09;
  localparam logic [7:0] VEC_RESERVED_TOP = 8'hFF;

  // level reported while a trap owns the pending register
  localparam logic [3:0] TRAP_LEVEL = 4'hF;
endpackage

// ===== trap_interrupt_status_control.sv
`timescale 1ns/1ps
module trap_interrupt_status_control
(
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic [trap_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [trap_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [trap_ctrl_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                           address_fault_event,
  input  wire logic                           stack_fault_event,
  input  wire logic                           clock_failure_event,
  input  wire logic                           dma_address_fault_event,
  input  wire logic                           loop_overflow_event,
  input  wire logic                           soft_hard_fault_event,
  input  wire logic                           timed_disable_in,
  input  wire logic                           priority_level_msb,
  input  wire logic [2:0]                     status_priority_bits,
  input  wire logic                           pending_valid,
  input  wire logic [7:0]                     pending_vector_in,
  input  wire logic [3:0]                     pending_level_in,
  input  wire logic [2:0]                     ext_irq_pin,
  output logic      [2:0]                     ext_irq_request,
  output logic                                trap_request,
  output logic                                interrupt_request,
  output logic      [3:0]                     cpu_priority_level,
  output logic                                irq
);
  import trap_ctrl_pkg::*;

  // sticky trap flags
  logic       address_fault_flag;
  logic       stack_fault_flag;
  logic       clock_failure_flag;
  logic       dma_address_soft_fault;
  logic       loop_stack_overflow_flag;
  logic       soft_generated_hard_fault;
  // control bits
  logic       global_irq_enable;
  logic       timed_disable_active;
  logic       software_trap_enable;
  logic [2:0] ext_irq_polarity;
  // pending vector register
  logic [3:0] new_priority_level;
  logic [7:0] pending_vector_number;
  // interrupt status and mask
  logic [EV_COUNT-1:0] event_status;
  logic [EV_COUNT-1:0] event_mask;
  // external input synchronisers
  logic [2:0] ext_sync1;
  logic [2:0] ext_sync2;
  logic [2:0] ext_prev;

  logic                wr_tsc1;
  logic                wr_geec;
  logic                wr_sts;
  logic                wr_htss;
  logic                wr_evs;
  logic                wr_evm;
  logic                soft_hard_taken;
  logic                any_trap;
  logic [2:0]          ext_edge;
  logic [3:0]          effective_level;
  logic [EV_COUNT-1:0] event_hits;

  // set beats a simultaneous software clear
  function automatic logic flag_next(input logic flag, input logic ev,
                                     input logic wr, input logic wbit);
    flag_next = ev | (wr ? wbit : flag);
  endfunction

  always_comb begin
    wr_tsc1 = reg_write && (reg_addr == OFS_TRAP_STATUS_CONTROL_ONE);
    wr_geec = reg_write && (reg_addr == OFS_GLOBAL_ENABLE_EDGE_CONTROL);
    wr_sts  = reg_write && (reg_addr == OFS_SOFT_TRAP_STATUS);
    wr_htss = reg_write && (reg_addr == OFS_HARD_TRAP_SOFTWARE_STATUS);
    wr_evs  = reg_write && (reg_addr == OFS_EVENT_STATUS);
    wr_evm  = reg_write && (reg_addr == OFS_EVENT_MASK);
  end

  // the software trap only counts while its enable bit is set
  assign soft_hard_taken = soft_hard_fault_event && software_trap_enable;

  assign any_trap = address_fault_event || stack_fault_event || clock_failure_event ||
                    dma_address_fault_event || loop_overflow_event || soft_hard_taken;

  assign effective_level = {priority_level_msb, status_priority_bits};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (ext_irq_polarity[i]) begin
        ext_edge[i] = ext_prev[i] && !ext_sync2[i];
      end else begin
        ext_edge[i] = !ext_prev[i] && ext_sync2[i];
      end
    end
  end

  always_comb begin
    event_hits              = '0;
    event_hits[EV_ADDRESS]  = address_fault_event;
    event_hits[EV_STACK]    = stack_fault_event;
    event_hits[EV_CLOCK]    = clock_failure_event;
    event_hits[EV_DMA]      = dma_address_fault_event;
    event_hits[EV_LOOP]     = loop_overflow_event;
    event_hits[EV_SOFTHW]   = soft_hard_taken;
    event_hits[EV_EXT+:3]   = ext_edge;
  end

  // highest urgency trap wins the vector
  function automatic logic [7:0] trap_vector(input logic clk_f, input logic adr_f,
                                             input logic hard_f, input logic stk_f,
                                             input logic dma_f);
    if (clk_f) begin
      trap_vector = VEC_CLOCK_FAIL;
    end else if (adr_f) begin
      trap_vector = VEC_ADDRESS;
    end else if (hard_f) begin
      trap_vector = VEC_HARD_GENERIC;
    end else if (stk_f) begin
      trap_vector = VEC_STACK;
    end else if (dma_f) begin
      trap_vector = VEC_DMA;
    end else begin
      trap_vector = VEC_SOFT_GENERIC;
    end
  endfunction

  // trap status flags
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      address_fault_flag        <= 1'b0;
      stack_fault_flag          <= 1'b0;
      clock_failure_flag        <= 1'b0;
      dma_address_soft_fault    <= 1'b0;
      loop_stack_overflow_flag  <= 1'b0;
      soft_generated_hard_fault <= 1'b0;
    end else begin
      address_fault_flag <= flag_next(address_fault_flag, address_fault_event, wr_tsc1,
                                      reg_wdata[POS_ADDRESS_FAULT]);
      stack_fault_flag   <= flag_next(stack_fault_flag, stack_fault_event, wr_tsc1,
                                      reg_wdata[POS_STACK_FAULT]);
      clock_failure_flag <= flag_next(clock_failure_flag, clock_failure_event, wr_tsc1,
                                      reg_wdata[POS_CLOCK_FAILURE]);
      dma_address_soft_fault <= flag_next(dma_address_soft_fault, dma_address_fault_event,
                                          wr_sts, reg_wdata[POS_DMA_SOFT_FAULT]);
      loop_stack_overflow_flag <= flag_next(loop_stack_overflow_flag, loop_overflow_event,
                                            wr_sts, reg_wdata[POS_LOOP_OVERFLOW]);
      soft_generated_hard_fault <= flag_next(soft_generated_hard_fault, soft_hard_taken,
                                             wr_htss, reg_wdata[POS_SOFT_HARD_FAULT]);
    end
  end

  // control bits; the timed disable status mirrors the core
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      global_irq_enable    <= RST_GLOBAL_ENABLE;
      software_trap_enable <= 1'b0;
      ext_irq_polarity     <= RST_EXT_POLARITY;
      timed_disable_active <= 1'b0;
    end else begin
      timed_disable_active <= timed_disable_in;
      if (wr_geec) begin
        global_irq_enable    <= reg_wdata[POS_GLOBAL_ENABLE];
        software_trap_enable <= reg_wdata[POS_SOFTWARE_TRAP];
        ext_irq_polarity     <= reg_wdata[POS_EXT_POLARITY+:3];
      end
    end
  end

  // two flops before any logic reads the pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ext_sync1 <= 3'h0;
      ext_sync2 <= 3'h0;
      ext_prev  <= 3'h0;
    end else begin
      ext_sync1 <= ext_irq_pin;
      ext_sync2 <= ext_sync1;
      ext_prev  <= ext_sync2;
    end
  end

  // pending vector and level; traps take the register over interrupts
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pending_vector_number <= RST_VECTOR;
      new_priority_level    <= RST_LEVEL;
    end else if (any_trap) begin
      pending_vector_number <= trap_vector(clock_failure_event, address_fault_event,
                                           soft_hard_taken, stack_fault_event,
                                           dma_address_fault_event);
      new_priority_level    <= TRAP_LEVEL;
    end else if (pending_valid && pending_vector_in != VEC_RESERVED_TOP) begin
      pending_vector_number <= pending_vector_in;
      new_priority_level    <= pending_level_in;
    end
  end

  // requests to the core
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trap_request       <= 1'b0;
      interrupt_request  <= 1'b0;
      ext_irq_request    <= 3'h0;
      cpu_priority_level <= RST_LEVEL;
    end else begin
      trap_request       <= any_trap;
      // a disabled global enable blocks interrupt_request only, not traps, ext_irq_request or irq
      interrupt_request  <= pending_valid && global_irq_enable &&
                            pending_vector_in != VEC_RESERVED_TOP &&
                            pending_level_in > effective_level;
      ext_irq_request    <= ext_edge;
      cpu_priority_level <= effective_level;
    end
  end

  // sticky event status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      event_status <= '0;
      event_mask   <= '0;
      irq          <= 1'b0;
    end else begin
      event_status <= event_hits | (event_status &
                      ~(wr_evs ? reg_wdata[EV_COUNT-1:0] : {EV_COUNT{1'b0}}));
      if (wr_evm) begin
        event_mask <= reg_wdata[EV_COUNT-1:0];
      end
      irq <= |(event_status & event_mask);
    end
  end

  // read port; unimplemented bits and unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= '0;
      case (reg_addr)
        OFS_TRAP_STATUS_CONTROL_ONE: begin
          reg_rdata[POS_ADDRESS_FAULT] <= address_fault_flag;
          reg_rdata[POS_STACK_FAULT]   <= stack_fault_flag;
          reg_rdata[POS_CLOCK_FAILURE] <= clock_failure_flag;
        end
        OFS_GLOBAL_ENABLE_EDGE_CONTROL: begin
          reg_rdata[POS_GLOBAL_ENABLE]      <= global_irq_enable;
          reg_rdata[POS_TIMED_DISABLE]      <= timed_disable_active;
          reg_rdata[POS_SOFTWARE_TRAP]      <= software_trap_enable;
          reg_rdata[POS_EXT_POLARITY+:3]    <= ext_irq_polarity;
        end
        OFS_SOFT_TRAP_STATUS: begin
          reg_rdata[POS_DMA_SOFT_FAULT] <= dma_address_soft_fault;
          reg_rdata[POS_LOOP_OVERFLOW]  <= loop_stack_overflow_flag;
        end
        OFS_HARD_TRAP_SOFTWARE_STATUS: begin
          reg_rdata[POS_SOFT_HARD_FAULT] <= soft_generated_hard_fault;
        end
        OFS_PENDING_VECTOR_LEVEL: begin
          reg_rdata[POS_NEW_LEVEL+:4] <= new_priority_level;
          reg_rdata[POS_VECTOR+:8]    <= pending_vector_number;
        end
        OFS_EVENT_STATUS: begin
          reg_rdata[EV_COUNT-1:0] <= event_status;
        end
        OFS_EVENT_MASK: begin
          reg_rdata[EV_COUNT-1:0] <= event_mask;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  addr_flag_set_a: assert property (address_fault_event |=> address_fault_flag)
    else $error("address fault flag not set");
  stack_flag_set_a: assert property (stack_fault_event |=> stack_fault_flag)
    else $error("stack fault flag not set");
  clock_flag_set_a: assert property (clock_failure_event |=> clock_failure_flag)
    else $error("clock failure flag not set");
  gie_blocks_irq_a: assert property (!global_irq_enable |=> !interrupt_request)
    else $error("interrupt requested while globally disabled");
  trap_always_a: assert property (any_trap && !global_irq_enable
    |=> trap_request)
    else $error("trap not serviced while interrupts disabled");
  timed_disable_active_mirror_a: assert property (timed_disable_active == $past(timed_disable_in))
    else $error("timed disable status does not follow core");
  software_trap_enable_gate_a: assert property (soft_hard_fault_event && !software_trap_enable &&
    !soft_generated_hard_fault && !wr_htss |=> !soft_generated_hard_fault)
    else $error("software trap taken while disabled");
  polarity_edge_a: assert property (ext_irq_polarity[0] && $fell(ext_sync2[0])
    |-> ##1 ext_irq_request[0] ##1 !ext_irq_request[0] || ext_edge[0])
    else $error("negative edge not detected");
  dma_flag_set_a: assert property (dma_address_fault_event |=> dma_address_soft_fault)
    else $error("dma soft fault flag not set");
  loop_flag_set_a: assert property (loop_overflow_event |=> loop_stack_overflow_flag)
    else $error("loop overflow flag not set");
  hard_flag_set_a: assert property (soft_hard_taken |=> soft_generated_hard_fault)
    else $error("software hard trap flag not set");
  level_report_a: assert property (pending_valid && !any_trap &&
    pending_vector_in != VEC_RESERVED_TOP |=> new_priority_level == $past(pending_level_in))
    else $error("new priority level not latched");
  vector_trap_a: assert property (clock_failure_event |=> pending_vector_number ==
    VEC_CLOCK_FAIL)
    else $error("clock failure vector wrong");
  vector_reserved_a: assert property (pending_vector_number != VEC_RESERVED_TOP)
    else $error("reserved vector reported");
  reserved_read_a: assert property (reg_read && reg_addr == OFS_PENDING_VECTOR_LEVEL
    |=> reg_rdata[15:12] == 4'h0)
    else $error("unimplemented bits read nonzero");
  level_concat_a: assert property (##1 cpu_priority_level ==
    {$past(priority_level_msb), $past(status_priority_bits)})
    else $error("effective priority level wrong");
  flag_hold_a: assert property (address_fault_flag && !wr_tsc1 |=> address_fault_flag)
    else $error("trap flag dropped without a write");
  flag_clear_a: assert property (wr_tsc1 && !reg_wdata[POS_STACK_FAULT] &&
    !stack_fault_event |=> !stack_fault_flag)
    else $error("trap flag not cleared by zero write");
  // trap level, reserved hold, vector priority, read-as-zero, flag hold, rising edge and trap pulse checks
  trap_level_a: assert property (any_trap |=> new_priority_level == TRAP_LEVEL)
    else $error("trap level not reported");
  reserved_hold_a: assert property (pending_valid && !any_trap &&
    pending_vector_in == VEC_RESERVED_TOP |=> $stable(pending_vector_number))
    else $error("reserved vector latched");
  stack_vector_a: assert property (stack_fault_event && !clock_failure_event &&
    !address_fault_event && !soft_hard_taken |=> pending_vector_number == VEC_STACK)
    else $error("stack error vector wrong");
  hard_vector_a: assert property (soft_hard_taken && !clock_failure_event &&
    !address_fault_event |=> pending_vector_number == VEC_HARD_GENERIC)
    else $error("software hard trap vector wrong");
  loop_vector_a: assert property (loop_overflow_event && !clock_failure_event &&
    !address_fault_event && !soft_hard_taken && !stack_fault_event &&
    !dma_address_fault_event |=> pending_vector_number == VEC_SOFT_GENERIC)
    else $error("loop overflow vector wrong");
  unmapped_read_a: assert property (reg_read && reg_addr == 3'h7
    |=> reg_rdata == 16'h0000)
    else $error("unmapped offset read nonzero");
  edge_ctrl_zero_a: assert property (reg_read &&
    reg_addr == OFS_GLOBAL_ENABLE_EDGE_CONTROL |=> reg_rdata[12:3] == 10'h000)
    else $error("unimplemented control bits read nonzero");
  dma_flag_hold_a: assert property (dma_address_soft_fault && !wr_sts
    |=> dma_address_soft_fault)
    else $error("dma soft fault flag dropped without a write");
  rise_detect_a: assert property (!ext_irq_polarity[1] && $rose(ext_sync2[1])
    |=> ext_irq_request[1])
    else $error("positive edge not detected");
  trap_pulse_a: assert property (!any_trap |=> !trap_request)
    else $error("trap request without a trap");
endmodule

// ===== core_peripheral_model.sv
`timescale 1ns/1ps
module core_peripheral_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [5:0] fire,
  input  wire logic       disable_cmd,
  input  wire logic [3:0] level_cmd,
  input  wire logic       pend_cmd,
  input  wire logic [7:0] vec_cmd,
  input  wire logic [3:0] lvl_cmd,
  input  wire logic [2:0] pin_cmd,
  output logic            address_fault_event,
  output logic            stack_fault_event,
  output logic            clock_failure_event,
  output logic            dma_address_fault_event,
  output logic            loop_overflow_event,
  output logic            soft_hard_fault_event,
  output logic            timed_disable_in,
  output logic            priority_level_msb,
  output logic [2:0]      status_priority_bits,
  output logic            pending_valid,
  output logic [7:0]      pending_vector_in,
  output logic [3:0]      pending_level_in,
  output logic [2:0]      ext_irq_pin
);
  // trap sources pulse for one cycle; the caller keeps fire one cycle wide
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      {soft_hard_fault_event, loop_overflow_event, dma_address_fault_event,
       clock_failure_event, stack_fault_event, address_fault_event} <= 6'h00;
    end else begin
      {soft_hard_fault_event, loop_overflow_event, dma_address_fault_event,
       clock_failure_event, stack_fault_event, address_fault_event} <= fire;
    end
  end
  // core and arbiter levels follow their commands one cycle late
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timed_disable_in <= 1'b0;
      {priority_level_msb, status_priority_bits} <= 4'h0;
      pending_valid <= 1'b0;
      pending_vector_in <= 8'h00;
      pending_level_in <= 4'h0;
      ext_irq_pin <= 3'h0;
    end else begin
      timed_disable_in <= disable_cmd;
      {priority_level_msb, status_priority_bits} <= level_cmd;
      pending_valid <= pend_cmd;
      // the reserved top code is passed on so the block must refuse it itself
      pending_vector_in <= vec_cmd;
      pending_level_in <= lvl_cmd;
      ext_irq_pin <= pin_cmd;
    end
  end
endmodule

// ===== trap_interrupt_status_control_tb.sv
`timescale 1ns/1ps
module trap_interrupt_status_control_tb;
  import trap_ctrl_pkg::*;
  typedef struct packed {
    logic [5:0]  fire;
    logic [2:0]  ofs;
    logic [15:0] flag;
    logic [7:0]  vec;
  } row_t;
  logic        sys_clk;
  logic        reset;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic [5:0]  fire;
  logic        disable_cmd;
  logic [3:0]  level_cmd;
  logic        pend_cmd;
  logic [7:0]  vec_cmd;
  logic [3:0]  lvl_cmd;
  logic [2:0]  pin_cmd;
  logic        ev_a, ev_s, ev_c, ev_d, ev_l, ev_h, tdis, pmsb, pval;
  logic [2:0]  pbits;
  logic [7:0]  pvec;
  logic [3:0]  plvl;
  logic [2:0]  pins;
  logic [2:0]  ext_irq_request;
  logic        trap_request;
  logic        interrupt_request;
  logic [3:0]  cpu_priority_level;
  logic        irq;
  logic [5:0]  watch;
  int          bad_count = 0;
  int          n_compared = 0;
  row_t        rows [6];

  assign watch = {irq, interrupt_request, trap_request, ext_irq_request};

  core_peripheral_model model (.sys_clk(sys_clk), .reset(reset), .fire(fire),
    .disable_cmd(disable_cmd), .level_cmd(level_cmd), .pend_cmd(pend_cmd), .vec_cmd(vec_cmd),
    .lvl_cmd(lvl_cmd), .pin_cmd(pin_cmd), .address_fault_event(ev_a), .stack_fault_event(ev_s),
    .clock_failure_event(ev_c), .dma_address_fault_event(ev_d), .loop_overflow_event(ev_l),
    .soft_hard_fault_event(ev_h), .timed_disable_in(tdis), .priority_level_msb(pmsb),
    .status_priority_bits(pbits), .pending_valid(pval), .pending_vector_in(pvec),
    .pending_level_in(plvl), .ext_irq_pin(pins));

  trap_interrupt_status_control uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .address_fault_event(ev_a), .stack_fault_event(ev_s), .clock_failure_event(ev_c),
    .dma_address_fault_event(ev_d), .loop_overflow_event(ev_l), .soft_hard_fault_event(ev_h),
    .timed_disable_in(tdis), .priority_level_msb(pmsb), .status_priority_bits(pbits),
    .pending_valid(pval), .pending_vector_in(pvec), .pending_level_in(plvl),
    .ext_irq_pin(pins), .ext_irq_request(ext_irq_request), .trap_request(trap_request),
    .interrupt_request(interrupt_request), .cpu_priority_level(cpu_priority_level), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // read data appear after the edge that samples the strobe and hold until the next read
  task automatic rdc(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    cmp16(reg_rdata, exp);
  endtask

  task automatic pulse(input logic [5:0] f);
    @(posedge sys_clk);
    fire <= f;
    @(posedge sys_clk);
    fire <= 6'h00;
  endtask

  // an output that must stay low for a whole window
  task automatic quiet(input int idx);
    bit hit;
    hit = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      hit = hit | (watch[idx] !== 1'b0);
    end
    cmp16({15'h0000, hit}, 16'h0000);
  endtask

  task automatic wait_lvl(input int idx, input logic lvl);
    bit ok;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge sys_clk);
      #1;
      ok = (watch[idx] === lvl);
    end
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, watch[idx], lvl);
      end_sim();
    end
  endtask

  initial begin
    rows[0] = '{6'h01, OFS_TRAP_STATUS_CONTROL_ONE, 16'h0008, VEC_ADDRESS};
    rows[1] = '{6'h02, OFS_TRAP_STATUS_CONTROL_ONE, 16'h0004, VEC_STACK};
    rows[2] = '{6'h04, OFS_TRAP_STATUS_CONTROL_ONE, 16'h0002, VEC_CLOCK_FAIL};
    rows[3] = '{6'h08, OFS_SOFT_TRAP_STATUS, 16'h0020, VEC_DMA};
    rows[4] = '{6'h10, OFS_SOFT_TRAP_STATUS, 16'h0010, VEC_SOFT_GENERIC};
    rows[5] = '{6'h20, OFS_HARD_TRAP_SOFTWARE_STATUS, 16'h0001, VEC_HARD_GENERIC};
    {reg_addr, reg_wdata, reg_write, reg_read, fire, disable_cmd} = '0;
    {level_cmd, pend_cmd, vec_cmd, lvl_cmd, pin_cmd} = '0;
    reset = 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rdc(OFS_TRAP_STATUS_CONTROL_ONE, 16'h0000);
    rdc(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h8000);
    rdc(OFS_SOFT_TRAP_STATUS, 16'h0000);
    rdc(OFS_HARD_TRAP_SOFTWARE_STATUS, 16'h0000);
    rdc(OFS_PENDING_VECTOR_LEVEL, 16'h0000);
    // software trap still disabled, so this request must leave no trace
    pulse(6'h20);
    repeat (4) @(posedge sys_clk);
    rdc(OFS_HARD_TRAP_SOFTWARE_STATUS, 16'h0000);
    wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'hA000);
    for (int i = 0; i < 6; i++) begin
      pulse(rows[i].fire);
      wait_lvl(3, 1'b1);
      rdc(rows[i].ofs, rows[i].flag);
      rdc(OFS_PENDING_VECTOR_LEVEL, {4'h0, TRAP_LEVEL, rows[i].vec});
      wr(rows[i].ofs, 16'h0000);
      rdc(rows[i].ofs, 16'h0000);
    end
    wr(OFS_TRAP_STATUS_CONTROL_ONE, 16'hFFFF);
    rdc(OFS_TRAP_STATUS_CONTROL_ONE, 16'h000E);
    wr(OFS_SOFT_TRAP_STATUS, 16'hFFFF);
    rdc(OFS_SOFT_TRAP_STATUS, 16'h0030);
    wr(OFS_HARD_TRAP_SOFTWARE_STATUS, 16'hFFFF);
    rdc(OFS_HARD_TRAP_SOFTWARE_STATUS, 16'h0001);
    wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'hFFFF);
    rdc(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'hA007);
    @(posedge sys_clk) disable_cmd <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'hE007);
    @(posedge sys_clk) disable_cmd <= 1'b0;
    wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h8000);
    rdc(3'h7, 16'h0000);
    @(posedge sys_clk);
    pend_cmd <= 1'b1;
    vec_cmd  <= VEC_CAPTURE_ONE;
    lvl_cmd  <= 4'h5;
    wait_lvl(4, 1'b1);
    rdc(OFS_PENDING_VECTOR_LEVEL, {4'h0, 4'h5, VEC_CAPTURE_ONE});
    @(posedge sys_clk) level_cmd <= 4'hB;
    repeat (3) @(posedge sys_clk);
    #1;
    cmp16({12'h000, cpu_priority_level}, 16'h000B);
    wait_lvl(4, 1'b0);
    @(posedge sys_clk) level_cmd <= 4'h0;
    wait_lvl(4, 1'b1);
    // interrupts blocked by the global enable while traps still get through
    wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h0000);
    wait_lvl(4, 1'b0);
    pulse(6'h01);
    wait_lvl(3, 1'b1);
    wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h8000);
    wait_lvl(4, 1'b1);
    @(posedge sys_clk) vec_cmd <= VEC_RESERVED_TOP;
    wait_lvl(4, 1'b0);
    rdc(OFS_PENDING_VECTOR_LEVEL, {4'h0, 4'h5, VEC_CAPTURE_ONE});
    @(posedge sys_clk) pend_cmd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h8000);
      @(posedge sys_clk) pin_cmd[i] <= 1'b1;
      wait_lvl(i, 1'b1);
      wr(OFS_GLOBAL_ENABLE_EDGE_CONTROL, 16'h8000 | (16'h0001 << i));
      @(posedge sys_clk) pin_cmd[i] <= 1'b0;
      wait_lvl(i, 1'b1);
      @(posedge sys_clk) pin_cmd[i] <= 1'b1;
      quiet(i);
    end
    wr(OFS_EVENT_STATUS, 16'h01FF);
    rdc(OFS_EVENT_STATUS, 16'h0000);
    pulse(6'h02);
    repeat (4) @(posedge sys_clk);
    #1;
    cmp16({15'h0000, irq}, 16'h0000);
    rdc(OFS_EVENT_STATUS, 16'h0002);
    wr(OFS_EVENT_MASK, 16'h0002);
    wait_lvl(5, 1'b1);
    wr(OFS_EVENT_STATUS, 16'h0002);
    wait_lvl(5, 1'b0);
    end_sim();
  end
endmodule
